/* File: rtl/sar_adc_cfg.svh */
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// Register byte addresses
`define REG_CTRL 8'h00
`define REG_SAMPLE 8'h04
`define REG_TRIG 8'h08
`define REG_STATUS 8'h0C
`define REG_MASK 8'h10
`define REG_CHMAP_LO 8'h14
`define REG_CHMAP_HI 8'h18
`define REG_RESULT_BASE 8'h40

// Control word fields
`define CTRL_ENABLE 0
`define CTRL_GAIN 1
`define CTRL_MODE_LSB 2
`define CTRL_MODE_MSB 3
`define CTRL_CLKSEL_LSB 4
`define CTRL_CLKSEL_MSB 5
`define CTRL_SCAN_LSB 6
`define CTRL_SCAN_MSB 9
`define CTRL_TEMP 10
`define CTRL_START 11

// Trigger word fields
`define TRIG_EN_LSB 0
`define TRIG_EN_MSB 3
`define TRIG_PRESET_LSB 8
`define TRIG_PRESET_MSB 11

// Status bits, mask uses the same layout
`define STAT_DONE 0
`define STAT_OVERRUN 1
`define STAT_BUSY 8
`define STAT_SLOT_LSB 12
`define STAT_SLOT_MSB 15

// Reset values
`define RST_SAMP_FIELD 4'h3
`define RST_CLKSEL 2'h0
`define RST_CHMAP 64'hFEDCBA9876543210

// Sampling: field plus this many converter clocks
`define SAMP_FIELD_MIN 4'h3
`define SAMP_EXTRA 5'h02
`define CONV_TOP_BIT 4'hB

// Converter clock rates in MHz and phase increments per system clock
`define SYS_CLK_MHZ 100
`define ADC_MHZ_24 24
`define ADC_MHZ_12 12
`define ADC_MHZ_6 6
`define ADC_MHZ_48 48
`define ADC_INC(mhz) (16'(((mhz) * 65536) / `SYS_CLK_MHZ))

`endif

/* File: rtl/sar_adc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_cfg.svh"
module sar_adc_ctrl
   import sar_adc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Timer trigger lines
   input wire logic timer_trigger_zero,
   input wire logic timer_trigger_one,
   input wire logic timer_trigger_two,
   input wire logic timer_trigger_three,
   // Analog converter core
   input wire logic cmp_above,
   output logic conv_enable,
   output logic converter_gain_select,
   output logic temp_sensor_enable,
   output logic sample_hold,
   output logic [3:0] chan_sel,
   output logic [11:0] dac_trial,
   // Interrupt
   output logic irq
);

   ctrl_s s;
   ctrl_s next_s;
   logic [3:0] trig_in;
   logic [3:0] trig_hit;
   logic [3:0] samp_eff;

   sar_step_if sif ();

   sar_step u_step (
      .sys_clk(sys_clk),
      .rst(rst),
      .sif(sif)
   );

   assign trig_in = {timer_trigger_three, timer_trigger_two,
      timer_trigger_one, timer_trigger_zero};

   // Per-line trigger gating
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_trig
         assign trig_hit[gi] = trig_in[gi] & s.trig_en[gi];
      end
   endgenerate

   // Field clamped so a bad setting cannot shorten sampling
   assign samp_eff = (s.samp_field < `SAMP_FIELD_MIN) ? `SAMP_FIELD_MIN
      : s.samp_field;

   // sampling clocks are field plus two
   assign sif.samp_cycles = {1'b0, samp_eff} + `SAMP_EXTRA;
   assign sif.tick = s.tick;
   assign sif.start = s.start;
   assign sif.abort = s.abort;
   assign sif.cmp = cmp_above;

   // Outputs straight from flip-flops
   assign reg_rdata = s.rdata;
   assign conv_enable = s.enable;
   assign converter_gain_select = s.gain;
   assign temp_sensor_enable = s.temp_en;
   assign chan_sel = s.chan;
   assign irq = s.irq;
   assign sample_hold = sif.sample;
   assign dac_trial = sif.trial;

   // Register file, trigger counting, sequencer and clock divider
   always_comb
   begin
      logic [16:0] acc_sum;
      logic [15:0] inc;
      logic [3:0] preset_eff;
      logic [3:0] cnt_inc;
      logic sw_start;
      logic hw_start;
      logic go;
      logic [1:0] set_bits;
      logic [1:0] clr_bits;
      logic single_ch;
      logic last_slot;
      acc_sum = '0;
      inc = '0;
      preset_eff = '0;
      cnt_inc = '0;
      sw_start = 1'b0;
      hw_start = 1'b0;
      go = 1'b0;
      set_bits = 2'b00;
      clr_bits = 2'b00;
      single_ch = 1'b0;
      last_slot = 1'b0;
      next_s = s;
      next_s.start = 1'b0;
      next_s.abort = 1'b0;
      next_s.rdata = 32'h00000000;

      // selected converter clock as a fractional tick
      unique case (s.clk_sel)
         2'b00: inc = `ADC_INC(`ADC_MHZ_24);
         2'b01: inc = `ADC_INC(`ADC_MHZ_12);
         2'b10: inc = `ADC_INC(`ADC_MHZ_6);
         2'b11: inc = `ADC_INC(`ADC_MHZ_48);
      endcase
      acc_sum = {1'b0, s.acc} + {1'b0, inc};
      next_s.acc = acc_sum[15:0];
      next_s.tick = acc_sum[16] & s.enable;

      // Register writes
      if (reg_wr)
      begin
         unique case (reg_addr)
            `REG_CTRL:
            begin
               next_s.enable = reg_wdata[`CTRL_ENABLE];
               next_s.gain = reg_wdata[`CTRL_GAIN];
               next_s.temp_en = reg_wdata[`CTRL_TEMP];
               next_s.mode = mode_e'(reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
               next_s.clk_sel = reg_wdata[`CTRL_CLKSEL_MSB:`CTRL_CLKSEL_LSB];
               next_s.scan_last = reg_wdata[`CTRL_SCAN_MSB:`CTRL_SCAN_LSB];
               sw_start = reg_wdata[`CTRL_START];
            end
            `REG_SAMPLE: next_s.samp_field = reg_wdata[3:0];
            `REG_TRIG:
            begin
               next_s.trig_en = reg_wdata[`TRIG_EN_MSB:`TRIG_EN_LSB];
               next_s.trig_preset =
                  reg_wdata[`TRIG_PRESET_MSB:`TRIG_PRESET_LSB];
               next_s.trig_count = 4'h0;
            end
            `REG_STATUS: clr_bits = reg_wdata[1:0];
            `REG_MASK: next_s.mask = reg_wdata[1:0];
            `REG_CHMAP_LO: next_s.chmap[31:0] = reg_wdata;
            `REG_CHMAP_HI: next_s.chmap[63:32] = reg_wdata;
            default:
            begin
            end
         endcase
      end

      // count enabled timer events up to the preset
      preset_eff = (s.trig_preset == 4'h0) ? 4'h1 : s.trig_preset;
      if (|trig_hit && s.enable)
      begin
         cnt_inc = s.trig_count + 4'h1;
         if (cnt_inc >= preset_eff)
         begin
            hw_start = 1'b1;
            next_s.trig_count = 4'h0;
         end
         else
         begin
            next_s.trig_count = cnt_inc;
         end
      end

      go = (sw_start | hw_start) & s.enable;
      single_ch = (s.mode == MODE_ONE_SINGLE) || (s.mode == MODE_ONE_CONT);
      last_slot = single_ch || (s.slot == s.scan_last);

      unique case (s.seq)
         SEQ_IDLE:
         begin
            if (go)
            begin
               next_s.slot = 4'h0;
               next_s.seq = SEQ_LAUNCH;
            end
         end
         SEQ_LAUNCH:
         begin
            next_s.chan = s.chmap[s.slot * 4 +: 4];
            next_s.start = 1'b1;
            next_s.seq = SEQ_WAIT;
         end
         SEQ_WAIT:
         begin
            if (sif.done)
            begin
               // result lands in its own slot
               next_s.result[s.slot] = sif.result;
               if (last_slot)
               begin
                  set_bits[`STAT_DONE] = 1'b1;
                  next_s.slot = 4'h0;
                  if ((s.mode == MODE_ONE_CONT) || (s.mode == MODE_SCAN_CONT))
                  begin
                     next_s.seq = SEQ_LAUNCH;
                  end
                  else
                  begin
                     next_s.seq = SEQ_IDLE;
                  end
               end
               else
               begin
                  next_s.slot = s.slot + 4'h1;
                  next_s.seq = SEQ_LAUNCH;
               end
            end
         end
         default:
         begin
            next_s.seq = SEQ_IDLE;
         end
      endcase

      // Starts while busy are dropped and flagged
      if (go && (s.seq != SEQ_IDLE))
      begin
         set_bits[`STAT_OVERRUN] = 1'b1;
      end

      // Disable stops any sequence immediately
      if (!next_s.enable && s.enable)
      begin
         next_s.seq = SEQ_IDLE;
         next_s.start = 1'b0;
         next_s.abort = 1'b1;
      end

      // sticky flags, a new event beats the clear
      next_s.status = (s.status & ~clr_bits) | set_bits;
      next_s.irq = |(next_s.status & next_s.mask);

      // Read data valid in the following cycle only
      if (reg_rd)
      begin
         if (reg_addr[7:6] == 2'b01)
         begin
            next_s.rdata = {20'h00000, s.result[reg_addr[5:2]]};
         end
         else
         begin
            unique case (reg_addr)
               `REG_CTRL: next_s.rdata = {21'h000000, s.temp_en,
                  s.scan_last, s.clk_sel, s.mode, s.gain, s.enable};
               `REG_SAMPLE: next_s.rdata = {28'h0000000, s.samp_field};
               `REG_TRIG: next_s.rdata = {16'h0000, s.trig_count,
                  s.trig_preset, 4'h0, s.trig_en};
               `REG_STATUS: next_s.rdata = {16'h0000, s.slot, 3'h0,
                  (s.seq != SEQ_IDLE) | sif.busy, 6'h00, s.status};
               `REG_MASK: next_s.rdata = {30'h00000000, s.mask};
               `REG_CHMAP_LO: next_s.rdata = s.chmap[31:0];
               `REG_CHMAP_HI: next_s.rdata = s.chmap[63:32];
               default: next_s.rdata = 32'h00000000;
            endcase
         end
      end
   end

   // State register; reset leaves the converter off
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.samp_field <= `RST_SAMP_FIELD;
         s.clk_sel <= `RST_CLKSEL;
         s.chmap <= `RST_CHMAP;
      end
      else
      begin
         s <= next_s;
      end
   end

endmodule : sar_adc_ctrl
`default_nettype wire

/* File: rtl/sar_adc_pkg.sv */
package sar_adc_pkg;

   typedef enum logic [1:0] {
      MODE_ONE_SINGLE = 2'b00,
      MODE_ONE_CONT = 2'b01,
      MODE_SCAN_SINGLE = 2'b10,
      MODE_SCAN_CONT = 2'b11
   } mode_e;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_LAUNCH = 2'b01,
      SEQ_WAIT = 2'b10
   } seq_e;

   typedef enum logic [1:0] {
      STEP_IDLE = 2'b00,
      STEP_SAMPLE = 2'b01,
      STEP_CONVERT = 2'b10
   } step_e;

   typedef struct packed {
      step_e st;
      logic [4:0] cnt;
      logic [3:0] bitn;
      logic [11:0] trial;
      logic [11:0] res;
      logic sample;
      logic done;
   } step_s;

   typedef struct packed {
      logic enable;
      logic gain;
      logic temp_en;
      mode_e mode;
      logic [1:0] clk_sel;
      logic [3:0] scan_last;
      logic [3:0] samp_field;
      logic [3:0] trig_en;
      logic [3:0] trig_preset;
      logic [3:0] trig_count;
      logic [1:0] status;
      logic [1:0] mask;
      logic [63:0] chmap;
      logic [15:0][11:0] result;
      seq_e seq;
      logic [3:0] slot;
      logic [3:0] chan;
      logic [15:0] acc;
      logic tick;
      logic start;
      logic abort;
      logic [31:0] rdata;
      logic irq;
   } ctrl_s;

endpackage : sar_adc_pkg

/* File: rtl/sar_step.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_cfg.svh"
module sar_step
   import sar_adc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Link to sequencer
   sar_step_if.step sif
);

   step_s s;
   step_s next_s;

   // Status seen by the sequencer
   assign sif.busy = (s.st != STEP_IDLE);
   assign sif.done = s.done;
   assign sif.result = s.res;
   assign sif.sample = s.sample;
   assign sif.trial = s.trial;

   // Sample then successive approximation, one step per converter tick
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      unique case (s.st)
         STEP_IDLE:
         begin
            if (sif.start)
            begin
               next_s.st = STEP_SAMPLE;
               next_s.cnt = sif.samp_cycles;
               next_s.sample = 1'b1;
            end
         end
         STEP_SAMPLE:
         begin
            if (sif.tick)
            begin
               if (s.cnt == 5'h01)
               begin
                  next_s.st = STEP_CONVERT;
                  next_s.sample = 1'b0;
                  next_s.bitn = `CONV_TOP_BIT;
                  next_s.trial = 12'h800;
               end
               else
               begin
                  next_s.cnt = s.cnt - 5'h01;
               end
            end
         end
         STEP_CONVERT:
         begin
            if (sif.tick)
            begin
               if (!sif.cmp)
               begin
                  next_s.trial[s.bitn] = 1'b0;
               end
               if (s.bitn == 4'h0)
               begin
                  next_s.res = next_s.trial;
                  next_s.trial = 12'h000;
                  next_s.done = 1'b1;
                  next_s.st = STEP_IDLE;
               end
               else
               begin
                  next_s.bitn = s.bitn - 4'h1;
                  next_s.trial[s.bitn - 4'h1] = 1'b1;
               end
            end
         end
         default:
         begin
            next_s.st = STEP_IDLE;
         end
      endcase
      // Disable drops a conversion in flight
      if (sif.abort)
      begin
         next_s.st = STEP_IDLE;
         next_s.sample = 1'b0;
         next_s.trial = 12'h000;
         next_s.done = 1'b0;
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

endmodule : sar_step
`default_nettype wire

/* File: rtl/sar_step_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sar_step_if;
   logic tick;
   logic start;
   logic abort;
   logic [4:0] samp_cycles;
   logic cmp;
   logic busy;
   logic done;
   logic [11:0] result;
   logic sample;
   logic [11:0] trial;

   modport ctrl (output tick, start, abort, samp_cycles, cmp,
      input busy, done, result, sample, trial);
   modport step (input tick, start, abort, samp_cycles, cmp,
      output busy, done, result, sample, trial);
endinterface : sar_step_if
`default_nettype wire

/* File: verif/analog_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module analog_core_model
(
   // Clock
   input wire logic sys_clk,
   // Converter controls
   input wire logic sample_hold,
   input wire logic [3:0] chan_sel,
   input wire logic [11:0] dac_trial,
   // Channel input levels
   input wire logic [15:0][11:0] vin,
   // Comparator
   output logic cmp_above
);
   logic [11:0] held = 12'h000;

   always @(posedge sys_clk)
   begin
      if (sample_hold)
      begin
         held <= vin[chan_sel];
      end
   end

   // Ideal comparator, no offset or delay
   assign cmp_above = (held >= dac_trial);
endmodule : analog_core_model
`default_nettype wire

/* File: verif/sar_adc_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_cfg.svh"
module sar_adc_checker
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Converter side
   input wire logic conv_enable,
   input wire logic converter_gain_select,
   input wire logic sample_hold,
   input wire logic [3:0] chan_sel,
   input wire logic [11:0] dac_trial,
   // Interrupt
   input wire logic irq
);
   logic [6:0] hold_len;
   logic [6:0] conv_len;

   // Phase lengths in system clocks; at the 24 MHz clock setting ticks land every 4 or 5 cycles
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         hold_len <= 7'h00;
         conv_len <= 7'h00;
      end
      else
      begin
         hold_len <= sample_hold ? hold_len + 7'h01 : 7'h00;
         conv_len <= (dac_trial != 12'h000) ? conv_len + 7'h01 : 7'h00;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Sampling phase begins and ends while enabled
   sequence enter_sample;
      $rose(sample_hold);
   endsequence
   sequence leave_sample;
      $fell(sample_hold) && conv_enable;
   endsequence

   // Five ticks of about 4.17 clocks, first tick 1 to 5 clocks out
   sample_len_a : assert property (
      leave_sample |-> hold_len >= 7'h11 && hold_len <= 7'h18)
      else $error("sampling phase length out of range");
   first_trial_a : assert property (
      leave_sample |-> ##[0:1] dac_trial == 12'h800)
      else $error("first trial code wrong after sampling");
   conv_len_a : assert property (
      $fell(dac_trial != 12'h000) && conv_enable
      |-> conv_len >= 7'h2C && conv_len <= 7'h38)
      else $error("conversion phase length out of range");
   start_enabled_a : assert property (
      enter_sample |-> conv_enable)
      else $error("sampling started while disabled");
   off_quiet_a : assert property (
      !conv_enable [*3] |-> !sample_hold && dac_trial == 12'h000)
      else $error("converter active while disabled");
   chan_hold_a : assert property (
      sample_hold && $past(sample_hold) |-> $stable(chan_sel))
      else $error("channel changed during sampling");
   gain_write_a : assert property (
      $changed(converter_gain_select)
      |-> $past(reg_wr) && $past(reg_addr) == `REG_CTRL)
      else $error("gain changed without control write");
   flag_hold_a : assert property (
      $fell(irq) |-> $past(reg_wr))
      else $error("interrupt dropped without a write");
   rdata_quiet_a : assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
endmodule : sar_adc_checker

bind sar_adc_ctrl sar_adc_checker chk (.sys_clk, .rst, .reg_addr, .reg_wr,
   .reg_rd, .reg_rdata, .conv_enable, .converter_gain_select, .sample_hold,
   .chan_sel, .dac_trial, .irq);
`default_nettype wire

/* File: verif/test_sar_adc_conversion_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_cfg.svh"
module test_sar_adc_conversion_control;
   logic sys_clk, rst, reg_wr, reg_rd, cmp_above, conv_enable, gain, temp;
   logic sample_hold, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [3:0] tl, chan_sel;
   logic [11:0] dac_trial;
   logic [15:0][11:0] vin;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;

   // Clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   sar_adc_ctrl uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .timer_trigger_zero(tl[0]),
      .timer_trigger_one(tl[1]), .timer_trigger_two(tl[2]),
      .timer_trigger_three(tl[3]), .cmp_above, .conv_enable,
      .converter_gain_select(gain), .temp_sensor_enable(temp), .sample_hold,
      .chan_sel, .dac_trial, .irq);

   analog_core_model core (.sys_clk, .sample_hold, .chan_sel, .dac_trial,
      .vin, .cmp_above);

   task check(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   // Bus write, one strobe cycle
   task wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Bus read; data stands only in the next cycle
   task rdr(logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask : rdr

   // Bounded wait for the completion interrupt
   task wait_irq();
      int n;
      n = 0;
      // Step off the edge so a clear written just now is seen
      #1;
      while (irq !== 1'b1 && n < 3000)
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      check("irq", {31'h0, irq}, 32'h1);
   endtask : wait_irq

   task pulse(int k);
      @(posedge sys_clk);
      tl[k] <= 1'b1;
      @(posedge sys_clk);
      tl[k] <= 1'b0;
   endtask : pulse

   task t_reset();
      rdr(`REG_CTRL);
      check("ctrl", rd, 32'h0);
      check("enable", {31'h0, conv_enable}, 32'h0);
      rdr(`REG_SAMPLE);
      check("sample", rd, 32'h3);
      rdr(`REG_CHMAP_LO);
      check("chmap", rd, 32'h76543210);
      rdr(8'h3C);
      check("unmapped", rd, 32'h0);
      // Fastest clock code, converter still off
      wr(`REG_CTRL, 32'h30);
      rdr(`REG_CTRL);
      check("clk sel", rd, 32'h30);
      $display("test reset done");
   endtask : t_reset

   task t_single();
      // Start request while disabled must be ignored
      wr(`REG_CTRL, 32'h800);
      repeat (20) @(posedge sys_clk);
      check("hold off", {31'h0, sample_hold}, 32'h0);
      repeat (600) @(posedge sys_clk);
      wr(`REG_SAMPLE, 32'h3);
      wr(`REG_MASK, 32'h1);
      vin[0] = 12'h5A3;
      wr(`REG_CTRL, 32'h1);
      #1 check("enable on", {31'h0, conv_enable}, 32'h1);
      wr(`REG_CTRL, 32'h801);
      wait_irq();
      rdr(`REG_RESULT_BASE);
      check("result0", rd, 32'h5A3);
      rdr(`REG_STATUS);
      check("done", {31'h0, rd[0]}, 32'h1);
      wr(`REG_STATUS, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 check("irq clear", {31'h0, irq}, 32'h0);
      $display("test single done");
   endtask : t_single

   task t_scan();
      for (int i = 0; i < 16; i++)
         vin[i] = 12'(i * 12'h111);
      wr(`REG_CTRL, 32'h7CB);
      #1 check("gain", {31'h0, gain}, 32'h1);
      check("temp", {31'h0, temp}, 32'h1);
      repeat (200) @(posedge sys_clk);
      wr(`REG_CTRL, 32'hFCB);
      wait_irq();
      for (int i = 0; i < 16; i++)
      begin
         rdr(8'(`REG_RESULT_BASE + 4 * i));
         check("scan result", rd, 32'(i * 12'h111));
      end
      wr(`REG_STATUS, 32'h1);
      $display("test scan done");
   endtask : t_scan

   task t_trig();
      vin[0] = 12'h3C5;
      for (int k = 0; k < 4; k++)
      begin
         wr(`REG_CTRL, 32'h1);
         wr(`REG_TRIG, 32'h200 | (32'h1 << k));
         pulse(k);
         repeat (10) @(posedge sys_clk);
         #1 check("early", {31'h0, sample_hold}, 32'h0);
         pulse(k);
         wait_irq();
         rdr(`REG_RESULT_BASE);
         check("trig result", rd, 32'h3C5);
         wr(`REG_STATUS, 32'h1);
      end
      $display("test trigger done");
   endtask : t_trig

   task t_cont();
      logic [31:0] c;
      for (int m = 1; m < 4; m += 2)
      begin
         c = 32'h41 | (32'(m) << 2);
         wr(`REG_CTRL, c);
         wr(`REG_CTRL, c | 32'h800);
         wait_irq();
         wr(`REG_STATUS, 32'h1);
         wait_irq();
         wr(`REG_CTRL, c | 32'h800);
         rdr(`REG_STATUS);
         check("overrun", {31'h0, rd[1]}, 32'h1);
         wr(`REG_CTRL, 32'h0);
         repeat (5) @(posedge sys_clk);
         #1 check("abort", {19'h0, sample_hold, dac_trial}, 32'h0);
         wr(`REG_STATUS, 32'h3);
      end
      $display("test continuous done");
   endtask : t_cont

   // Cut a hang short
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         finish_test();
      end
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      tl = 4'h0;
      vin = '0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_single();
      t_scan();
      t_trig();
      t_cont();
      finish_test();
   end
endmodule : test_sar_adc_conversion_control
`default_nettype wire
